// ### core/atab_pkg.sv
// ==========================================================================
// Shared constants for the advertising telegram builder.
// ==========================================================================
package atab_pkg;
   // Frame framing bytes.
   localparam logic [31:0] ACCESS_ADDR = 32'h8E89_BED6; // Advertising access address.
   localparam logic [7:0] HDR_TYPE = 8'h42; // Non-connectable advertising, random address.
   localparam logic [7:0] HDR_LEN_DATA = 8'h13; // Address plus payload, data frame.
   localparam logic [7:0] HDR_LEN_COMM = 8'h24; // Address plus payload, commissioning.
   localparam logic [7:0] PLEN_DATA = 8'h0C; // Vendor content length, data frame.
   localparam logic [7:0] PLEN_COMM = 8'h1D; // Vendor content length, commissioning.
   localparam logic [7:0] PTYPE_VENDOR = 8'hFF; // Manufacturer-specific data type.
   // Byte positions inside a frame.
   localparam logic [5:0] POS_HDR = 6'h04; // First header byte.
   localparam logic [5:0] POS_LEN = 6'h05; // Header length byte.
   localparam logic [5:0] POS_ADDR = 6'h06; // Source address, six bytes.
   localparam logic [5:0] POS_PLEN = 6'h0C; // Payload length byte.
   localparam logic [5:0] POS_PTYPE = 6'h0D; // Payload type byte.
   localparam logic [5:0] POS_VEND = 6'h0E; // Vendor code, two bytes.
   localparam logic [5:0] POS_SEQ = 6'h10; // Sequence counter, four bytes.
   localparam logic [5:0] POS_STATE = 6'h14; // Input state byte.
   localparam logic [5:0] POS_SIG = 6'h15; // Signature, four bytes.
   localparam logic [5:0] POS_KEY = 6'h14; // Key, sixteen bytes.
   localparam logic [5:0] POS_CADDR = 6'h24; // Static address copy, six bytes.
   localparam logic [5:0] CRC_POS_DATA = 6'h19; // First CRC byte, data frame.
   localparam logic [5:0] CRC_POS_COMM = 6'h2A; // First CRC byte, commissioning.
   localparam logic [5:0] CRC_BYTES = 6'h03; // CRC length in bytes.
   // CRC generator.
   localparam logic [23:0] CRC_POLY = 24'h00_065B; // Advertising channel polynomial.
   localparam logic [23:0] CRC_INIT = 24'h55_5555; // Advertising channel preset.
   // Authentication constants.
   localparam logic [2:0] SIG_ENC = 3'h1; // Signature size 4, halved minus one.
   localparam logic [2:0] LFS_ENC = 3'h1; // Length field size 2, minus one.
   localparam logic [7:0] CTR_FLAG = {5'h00, LFS_ENC}; // counter_block_flag.
   localparam logic [7:0] MAC_FLAG = {2'h1, SIG_ENC, LFS_ENC}; // mac_block_flag.
   localparam logic [15:0] IN_LEN = 16'h0009; // Authenticated byte count.
   localparam logic [3:0] AES_ROUNDS = 4'hA; // Rounds of the block cipher.
   // Controller states.
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_MAC1 = 5'h02,
      ST_MAC2 = 5'h04,
      ST_CTR = 5'h08,
      ST_EMIT = 5'h10
   } atab_state_e;
endpackage : atab_pkg

// ### core/atab_builder.sv
`timescale 1ns/10ps
// ==========================================================================
// Summary of operation
// - Frames open with advertising access address.
// - Multi-byte fields go out little-endian, except key, signature and CRC, top byte first.
// - Header length byte 0x13 or 0x24.
// - Six-byte source address follows header.
// - Data frame payload length byte 0x0C.
// - Payload type byte is 0xFF.
// - Two-byte vendor code follows type byte.
// - Three CRC bytes end every frame.
// - Data payload: counter, state, signature.
// - State 01 means press, contacts open.
// - Commissioning payload length byte 0x1D.
// - Commissioning: counter, key, static address.
// - Counter increments every telegram.
// - Signature uses counter-with-CBC-MAC scheme.
// - Length field is two bytes.
// - Signature is four bytes.
// - Nonce address is least byte first.
// - Nine authenticated bytes in frame order.
// - Input length encoded 0x0009.
// - Sixteen-byte key shared with verifier.
// - Encoded sizes both equal one.
// - Flags are 0x01 and 0x49.
// - Nonce: address, counter, zero pad.
// - Flag, nonce, two zero bytes.
// - Length, input bytes, five zero bytes.
// - Three ciphers, two XORs, first four bytes.
// ==========================================================================
module atab_builder #(
   parameter logic [15:0] VENDOR_CODE = 16'h5A5A, // Arbitrary value, not a real maker.
   parameter logic [31:0] SEQ_INIT = 32'h0000_0000 // Counter value after reset.
) (
   // Clock, reset and enable.
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   // Telegram request.
   input wire logic i_send,
   input wire logic i_commission,
   input wire logic i_actuator_press,
   input wire logic i_contact_input_a,
   input wire logic i_contact_input_b,
   input wire logic [47:0] i_src_addr,
   input wire logic [127:0] i_key,
   // Status.
   output logic o_busy,
   output logic [31:0] o_seq_count,
   output logic [31:0] o_signature,
   // Byte stream toward the radio.
   output logic [7:0] o_tx_data,
   output logic o_tx_valid,
   output logic o_tx_last,
   input wire logic i_tx_ready
);
   // ======================================================================
   // Arithmetic helpers for the block cipher and CRC.
   // ======================================================================
   // Multiply by two in the cipher field.
   function automatic logic [7:0] xt(input logic [7:0] a);
      return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
   endfunction : xt

   // General field multiply, shift-and-add.
   function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      logic [7:0] aa;
      p = 8'h00;
      aa = a;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) begin
            p = p ^ aa;
         end
         aa = xt(aa);
      end
      return p;
   endfunction : gmul

   // Substitution computed from the field inverse; avoids a 256-entry table.
   function automatic logic [7:0] sbox(input logic [7:0] x);
      logic [7:0] sq;
      logic [7:0] r;
      sq = x;
      r = 8'h01;
      for (int i = 1; i < 8; i++) begin
         sq = gmul(sq, sq);
         r = gmul(r, sq);
      end
      return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
         ^ {r[3:0], r[7:4]} ^ 8'h63;
   endfunction : sbox

   // Next round key from the current one.
   function automatic logic [127:0] next_key(input logic [127:0] k, input logic [7:0] rc);
      logic [31:0] t;
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      t = {sbox(k[23:16]) ^ rc, sbox(k[15:8]), sbox(k[7:0]), sbox(k[31:24])};
      w0 = k[127:96] ^ t;
      w1 = k[95:64] ^ w0;
      w2 = k[63:32] ^ w1;
      w3 = k[31:0] ^ w2;
      return {w0, w1, w2, w3};
   endfunction : next_key

   // One cipher round; byte 0 sits in the top bits.
   function automatic logic [127:0] aes_round(input logic [127:0] s, input logic [127:0] k,
                                              input logic last);
      logic [7:0] b [16];
      logic [7:0] m [16];
      logic [127:0] o;
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            b[4*c+r] = sbox(s[127-8*(4*((c+r)%4)+r) -: 8]);
         end
      end
      for (int c = 0; c < 4; c++) begin
         m[4*c] = xt(b[4*c]) ^ gmul(b[4*c+1], 8'h03) ^ b[4*c+2] ^ b[4*c+3];
         m[4*c+1] = b[4*c] ^ xt(b[4*c+1]) ^ gmul(b[4*c+2], 8'h03) ^ b[4*c+3];
         m[4*c+2] = b[4*c] ^ b[4*c+1] ^ xt(b[4*c+2]) ^ gmul(b[4*c+3], 8'h03);
         m[4*c+3] = gmul(b[4*c], 8'h03) ^ b[4*c+1] ^ b[4*c+2] ^ xt(b[4*c+3]);
      end
      o = '0;
      for (int i = 0; i < 16; i++) begin
         o[127-8*i -: 8] = last ? b[i] : m[i];
      end
      return o ^ k;
   endfunction : aes_round

   // Advance the CRC over one byte, least significant bit first.
   function automatic logic [23:0] crc_byte(input logic [23:0] c, input logic [7:0] d);
      logic [23:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[23] ^ d[i];
         r = {r[22:0], 1'b0} ^ (fb ? atab_pkg::CRC_POLY : 24'h00_0000);
      end
      return r;
   endfunction : crc_byte

   // Reverse a byte so the register's top bit leaves the radio first.
   function automatic logic [7:0] rev8(input logic [7:0] d);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = d[7-i];
      end
      return r;
   endfunction : rev8

   // ======================================================================
   // Control state.
   // ======================================================================
   atab_pkg::atab_state_e state_reg, state_next; // Controller state.
   logic [31:0] seq_reg, seq_next; // Free-running telegram counter.
   logic [31:0] seql_reg, seql_next; // Counter value of the current telegram.
   logic [47:0] addr_reg, addr_next; // Latched source address.
   logic [127:0] key_reg, key_next; // Latched signing key.
   logic [7:0] inst_reg, inst_next; // Latched input state byte.
   logic comm_reg, comm_next; // Current frame is commissioning.
   logic [127:0] aes_reg, aes_next; // Cipher state.
   logic [127:0] rk_reg, rk_next; // Round key.
   logic [7:0] rcon_reg, rcon_next; // Round constant.
   logic [3:0] rnd_reg, rnd_next; // Round counter, zero means load.
   logic [127:0] mac_reg, mac_next; // Chained MAC value.
   logic [31:0] sig_reg, sig_next; // Finished signature.
   logic [5:0] idx_reg, idx_next; // Byte index of the frame.
   logic [23:0] crc_reg, crc_next; // Running CRC.
   // Derived blocks and stream signals.
   logic [127:0] rk_rnd; // Key used by the present round.
   logic [127:0] aes_out; // Result of the present round.
   logic [127:0] blk_in; // Block loaded at round zero.
   logic [103:0] nonce; // Thirteen-byte nonce.
   logic [127:0] a0_blk; // Counter block.
   logic [127:0] b0_blk; // First MAC block.
   logic [127:0] b1_blk; // Second MAC block.
   logic [47:0] addr_le; // Address, least byte first.
   logic [31:0] seq_le; // Counter, least byte first.
   logic [5:0] crc_pos; // First CRC byte of this frame.
   logic [7:0] push_data; // Byte offered to the buffer.
   logic push_last; // Offered byte ends the frame.
   logic push; // Byte enters the buffer.
   logic buf_ready; // Buffer has a free entry.

   // Block and nonce layout; the radio reads addresses low byte first.
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         addr_le[47-8*i -: 8] = addr_reg[8*i +: 8];
      end
      for (int i = 0; i < 4; i++) begin
         seq_le[31-8*i -: 8] = seql_reg[8*i +: 8];
      end
      nonce = {addr_le, seq_le, 24'h00_0000};
      a0_blk = {atab_pkg::CTR_FLAG, nonce, 16'h0000};
      b0_blk = {atab_pkg::MAC_FLAG, nonce, 16'h0000};
      b1_blk = {atab_pkg::IN_LEN, atab_pkg::PLEN_DATA, atab_pkg::PTYPE_VENDOR,
                VENDOR_CODE[7:0], VENDOR_CODE[15:8], seq_le, inst_reg,
                40'h00_0000_0000};
      crc_pos = comm_reg ? atab_pkg::CRC_POS_COMM : atab_pkg::CRC_POS_DATA;
   end

   // Cipher datapath shared by the three block operations.
   always_comb begin
      rk_rnd = next_key(rk_reg, rcon_reg);
      aes_out = aes_round(aes_reg, rk_rnd, rnd_reg == atab_pkg::AES_ROUNDS);
      case (state_reg)
         atab_pkg::ST_MAC1: blk_in = b0_blk;
         atab_pkg::ST_MAC2: blk_in = mac_reg ^ b1_blk;
         default: blk_in = a0_blk;
      endcase
   end

   // Byte selector for the outgoing frame.
   always_comb begin
      push_data = 8'h00;
      push_last = (idx_reg == crc_pos + atab_pkg::CRC_BYTES - 6'h01);
      if (idx_reg < atab_pkg::POS_HDR) begin
         push_data = atab_pkg::ACCESS_ADDR[8*idx_reg[1:0] +: 8];
      end else if (idx_reg == atab_pkg::POS_HDR) begin
         push_data = atab_pkg::HDR_TYPE;
      end else if (idx_reg == atab_pkg::POS_LEN) begin
         push_data = comm_reg ? atab_pkg::HDR_LEN_COMM : atab_pkg::HDR_LEN_DATA;
      end else if (idx_reg < atab_pkg::POS_PLEN) begin
         push_data = addr_le[47-8*(idx_reg-atab_pkg::POS_ADDR) -: 8];
      end else if (idx_reg == atab_pkg::POS_PLEN) begin
         push_data = comm_reg ? atab_pkg::PLEN_COMM : atab_pkg::PLEN_DATA;
      end else if (idx_reg == atab_pkg::POS_PTYPE) begin
         push_data = atab_pkg::PTYPE_VENDOR;
      end else if (idx_reg < atab_pkg::POS_SEQ) begin
         push_data = VENDOR_CODE[8*(idx_reg-atab_pkg::POS_VEND) +: 8];
      end else if (idx_reg < atab_pkg::POS_STATE) begin
         push_data = seq_le[31-8*(idx_reg-atab_pkg::POS_SEQ) -: 8];
      end else if (idx_reg >= crc_pos) begin
         push_data = rev8(crc_reg[23-8*(idx_reg-crc_pos) -: 8]);
      end else if (!comm_reg && idx_reg == atab_pkg::POS_STATE) begin
         push_data = inst_reg;
      end else if (!comm_reg) begin
         push_data = sig_reg[31-8*(idx_reg-atab_pkg::POS_SIG) -: 8];
      end else if (idx_reg < atab_pkg::POS_CADDR) begin
         push_data = key_reg[127-8*(idx_reg-atab_pkg::POS_KEY) -: 8];
      end else begin
         push_data = addr_le[47-8*(idx_reg-atab_pkg::POS_CADDR) -: 8];
      end
      push = (state_reg == atab_pkg::ST_EMIT) && buf_ready;
   end

   // Next-state logic of the controller.
   always_comb begin
      state_next = state_reg;
      seq_next = seq_reg;
      seql_next = seql_reg;
      addr_next = addr_reg;
      key_next = key_reg;
      inst_next = inst_reg;
      comm_next = comm_reg;
      aes_next = aes_reg;
      rk_next = rk_reg;
      rcon_next = rcon_reg;
      rnd_next = rnd_reg;
      mac_next = mac_reg;
      sig_next = sig_reg;
      idx_next = idx_reg;
      crc_next = crc_reg;
      case (state_reg)
         atab_pkg::ST_IDLE: begin
            // Inputs are caught once so a frame never mixes two requests.
            if (i_send) begin
               addr_next = i_src_addr;
               key_next = i_key;
               inst_next = {5'h00, i_contact_input_b, i_contact_input_a,
                            i_actuator_press};
               comm_next = i_commission;
               seql_next = seq_reg;
               seq_next = seq_reg + 32'h0000_0001;
               rnd_next = 4'h0;
               idx_next = 6'h00;
               crc_next = atab_pkg::CRC_INIT;
               state_next = i_commission ? atab_pkg::ST_EMIT : atab_pkg::ST_MAC1;
            end
         end
         atab_pkg::ST_MAC1, atab_pkg::ST_MAC2, atab_pkg::ST_CTR: begin
            if (rnd_reg == 4'h0) begin
               aes_next = blk_in ^ key_reg;
               rk_next = key_reg;
               rcon_next = 8'h01;
               rnd_next = 4'h1;
            end else begin
               aes_next = aes_out;
               rk_next = rk_rnd;
               rcon_next = xt(rcon_reg);
               rnd_next = rnd_reg + 4'h1;
               if (rnd_reg == atab_pkg::AES_ROUNDS) begin
                  rnd_next = 4'h0;
                  // Chain X1, then X2, then mask X2 with the counter block.
                  if (state_reg == atab_pkg::ST_MAC1) begin
                     mac_next = aes_out;
                     state_next = atab_pkg::ST_MAC2;
                  end else if (state_reg == atab_pkg::ST_MAC2) begin
                     mac_next = aes_out;
                     state_next = atab_pkg::ST_CTR;
                  end else begin
                     sig_next = mac_reg[127:96] ^ aes_out[127:96];
                     state_next = atab_pkg::ST_EMIT;
                  end
               end
            end
         end
         atab_pkg::ST_EMIT: begin
            // The CRC skips the access address and stops before its own bytes.
            if (push) begin
               idx_next = idx_reg + 6'h01;
               if (idx_reg >= atab_pkg::POS_HDR && idx_reg < crc_pos) begin
                  crc_next = crc_byte(crc_reg, push_data);
               end
               if (push_last) begin
                  state_next = atab_pkg::ST_IDLE;
               end
            end
         end
         default: state_next = atab_pkg::ST_IDLE;
      endcase
   end

   // Controller registers; the enable freezes everything.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_reg <= atab_pkg::ST_IDLE;
         seq_reg <= SEQ_INIT;
         seql_reg <= 32'h0000_0000;
         addr_reg <= 48'h0000_0000_0000;
         key_reg <= '0;
         inst_reg <= 8'h00;
         comm_reg <= 1'b0;
         aes_reg <= '0;
         rk_reg <= '0;
         rcon_reg <= 8'h01;
         rnd_reg <= 4'h0;
         mac_reg <= '0;
         sig_reg <= 32'h0000_0000;
         idx_reg <= 6'h00;
         crc_reg <= atab_pkg::CRC_INIT;
      end else if (i_clk_en) begin
         state_reg <= state_next;
         seq_reg <= seq_next;
         seql_reg <= seql_next;
         addr_reg <= addr_next;
         key_reg <= key_next;
         inst_reg <= inst_next;
         comm_reg <= comm_next;
         aes_reg <= aes_next;
         rk_reg <= rk_next;
         rcon_reg <= rcon_next;
         rnd_reg <= rnd_next;
         mac_reg <= mac_next;
         sig_reg <= sig_next;
         idx_reg <= idx_next;
         crc_reg <= crc_next;
      end
   end

   // ======================================================================
   // Two-entry output buffer; a stalled radio never drops a byte.
   // ======================================================================
   logic [8:0] mem_reg [2]; // Entries hold last flag and byte.
   logic [8:0] mem_next [2];
   logic wp_reg, wp_next; // Write pointer.
   logic rp_reg, rp_next; // Read pointer.
   logic [1:0] cnt_reg, cnt_next; // Filled entries.
   logic pop; // Radio takes a byte.

   // Pointer and count update.
   always_comb begin
      mem_next = mem_reg;
      wp_next = wp_reg;
      rp_next = rp_reg;
      buf_ready = (cnt_reg != 2'h2);
      pop = (cnt_reg != 2'h0) && i_tx_ready;
      if (push) begin
         mem_next[wp_reg] = {push_last, push_data};
         wp_next = ~wp_reg;
      end
      if (pop) begin
         rp_next = ~rp_reg;
      end
      cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   end

   // Buffer registers.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         mem_reg[0] <= 9'h000;
         mem_reg[1] <= 9'h000;
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
      end else if (i_clk_en) begin
         mem_reg <= mem_next;
         wp_reg <= wp_next;
         rp_reg <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   // Outputs; stream handshakes are plain functions of the buffer flops.
   assign o_tx_data = mem_reg[rp_reg][7:0];
   assign o_tx_last = mem_reg[rp_reg][8];
   assign o_tx_valid = (cnt_reg != 2'h0);
   assign o_busy = (state_reg != atab_pkg::ST_IDLE) || (cnt_reg != 2'h0);
   assign o_seq_count = seq_reg;
   assign o_signature = sig_reg;

   // ======================================================================
   // Checks.
   // ======================================================================
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   sequence s_accept;
      (state_reg == atab_pkg::ST_IDLE) && i_send && i_clk_en;
   endsequence
   sequence s_byte(logic [5:0] pos);
      push && i_clk_en && (idx_reg == pos);
   endsequence

   access_addr_a: assert property (s_byte(6'h00) |-> push_data == 8'hD6)
      else $error("First frame byte is not the access address low byte.");
   header_len_a: assert property (s_byte(atab_pkg::POS_LEN) |->
      push_data == (comm_reg ? 8'h24 : 8'h13))
      else $error("Header length byte is wrong.");
   payload_len_a: assert property (s_byte(atab_pkg::POS_PLEN) |->
      push_data == (comm_reg ? 8'h1D : 8'h0C))
      else $error("Payload length byte is wrong.");
   payload_type_a: assert property (s_byte(atab_pkg::POS_PTYPE) |-> push_data == 8'hFF)
      else $error("Payload type byte is wrong.");
   seq_step_a: assert property (s_accept |=> seq_reg == $past(seq_reg) + 32'h0000_0001)
      else $error("Sequence counter did not step by one.");
   auth_path_a: assert property (s_accept ##1 (!comm_reg && i_clk_en) [*2] |->
      state_reg == atab_pkg::ST_MAC1)
      else $error("Data frame skipped the signing pass.");
   block_flags_a: assert property ((state_reg == atab_pkg::ST_MAC1) |->
      b0_blk[127:120] == 8'h49 && a0_blk[127:120] == 8'h01 && b1_blk[15:0] == 16'h0000)
      else $error("Block flags are wrong.");
   sig_byte_a: assert property (s_byte(atab_pkg::POS_SIG) ##0 !comm_reg |->
      push_data == sig_reg[31:24])
      else $error("Signature byte order is wrong.");
   crc_hold_a: assert property (push && i_clk_en && idx_reg >= crc_pos |=>
      crc_reg == $past(crc_reg))
      else $error("CRC moved while its bytes were sent.");
   frame_end_a: assert property (push && i_clk_en && push_last |=>
      state_reg == atab_pkg::ST_IDLE && idx_reg == (comm_reg ? 6'h2D : 6'h1C))
      else $error("Frame length is wrong.");
endmodule : atab_builder

// ### dv/atab_radio_sink.sv
`timescale 1ns/10ps
// ==========================================================================
// Receiver stand-in: accepts bytes, stalling at random so the buffer fills.
// ==========================================================================
module atab_radio_sink (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // Byte stream handshake.
   input wire logic i_tx_valid,
   output logic o_tx_ready
);
   logic [15:0] lfsr_reg = 16'hACE1; // Stall pattern source.
   // Ready changes just after each edge; long stalls exercise the full buffer.
   always @(posedge i_ref_clk) begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      o_tx_ready <= #1 !i_reset && (lfsr_reg[1:0] != 2'h0);
   end
endmodule : atab_radio_sink

// ### dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
// ==========================================================================
// Bench: drives requests, queues expected bytes, a monitor compares.
// ==========================================================================
module tb_top;
   logic clk = 0, rst = 1, snd = 0, cm = 0, pr = 0, ca = 0, cb = 0, en = 1, busy, valid, last, rdy;
   logic [47:0] addr = 0;
   logic [127:0] key = 0;
   logic [31:0] seq, sig, rs = 32'h51eb_4290, eseq = 0, esig = 0;
   logic [7:0] data;
   logic [8:0] expq[$]; // Each note: last flag, byte.
   int n_fail = 0, n_checks = 0;
   always #2 clk = ~clk;
   atab_builder #(.VENDOR_CODE(16'h5A5A), .SEQ_INIT(32'h0000_0000)) atab_builder_i (
      .i_ref_clk(clk), .i_reset(rst), .i_clk_en(en), .i_send(snd), .i_commission(cm),
      .i_actuator_press(pr), .i_contact_input_a(ca), .i_contact_input_b(cb), .i_src_addr(addr),
      .i_key(key), .o_busy(busy), .o_seq_count(seq), .o_signature(sig), .o_tx_data(data),
      .o_tx_valid(valid), .o_tx_last(last), .i_tx_ready(rdy));
   atab_radio_sink atab_radio_sink_i (.i_ref_clk(clk), .i_reset(rst), .i_tx_valid(valid),
      .o_tx_ready(rdy));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13); rs = rs ^ (rs >> 17); rs = rs ^ (rs << 5);
      return rs;
   endfunction : xs
   // Field multiply and substitution, written from the cipher's definition.
   function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (b[i]) p = p ^ a;
         a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
      end
      return p;
   endfunction : gm
   function automatic logic [7:0] sb(input logic [7:0] x);
      logic [7:0] r;
      r = 8'h01;
      for (int i = 0; i < 254; i++) r = gm(r, x);
      return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^ {r[3:0], r[7:4]} ^ 8'h63;
   endfunction : sb
   // Reference block cipher, byte 0 in the top bits.
   function automatic logic [127:0] aes(input logic [127:0] p, input logic [127:0] k);
      logic [7:0] s[16], t[16], w[16], rc;
      rc = 8'h01;
      for (int i = 0; i < 16; i++) begin
         w[i] = k[127-8*i-:8];
         s[i] = p[127-8*i-:8] ^ w[i];
      end
      for (int r = 1; r <= 10; r++) begin
         t[0] = sb(w[13]) ^ rc;
         t[1] = sb(w[14]);
         t[2] = sb(w[15]);
         t[3] = sb(w[12]);
         for (int i = 0; i < 16; i++) w[i] = w[i] ^ (i < 4 ? t[i] : w[(i+12)%16]);
         rc = gm(rc, 8'h02);
         for (int i = 0; i < 16; i++) t[i] = sb(s[(i + 4*(i%4)) % 16]);
         for (int i = 0; i < 16; i++) s[i] = (r == 10) ? t[i] ^ w[i] : gm(t[i], 8'h02)
            ^ gm(t[i/4*4+(i+1)%4], 8'h03) ^ t[i/4*4+(i+2)%4] ^ t[i/4*4+(i+3)%4] ^ w[i];
      end
      for (int i = 0; i < 16; i++) p[127-8*i-:8] = s[i];
      return p;
   endfunction : aes
   task automatic summarize();
      if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Sends one telegram and notes every byte it must produce.
   task automatic send(input logic comm, input logic [2:0] st);
      logic [7:0] f[$];
      logic [23:0] c;
      logic fb;
      logic [7:0] rb;
      logic [127:0] b0, b1, t0;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 900) begin @(posedge clk); #1; en = |(xs() & 32'h3); n++; end
      if (n == 900) begin n_fail++; summarize(); end
      `CHK(sig, esig)
      en = 1'b1;
      addr = {16'(xs()), xs()};
      key = {xs(), xs(), xs(), xs()};
      {snd, cm, cb, ca, pr} = {1'b1, comm, st};
      f = {8'hD6, 8'hBE, 8'h89, 8'h8E, 8'h42, comm ? 8'h24 : 8'h13};
      for (int i = 0; i < 6; i++) f.push_back(addr[8*i+:8]);
      f.push_back(comm ? 8'h1D : 8'h0C);
      f = {f, 8'hFF, 8'h5A, 8'h5A};
      for (int i = 0; i < 4; i++) f.push_back(eseq[8*i+:8]);
      if (comm) begin
         for (int i = 0; i < 16; i++) f.push_back(key[127-8*i-:8]);
         for (int i = 0; i < 6; i++) f.push_back(addr[8*i+:8]);
      end else begin
         f.push_back({5'h00, st});
         b0 = {8'h49, 120'h0};
         b1 = {16'h0009, 112'h0};
         for (int i = 0; i < 10; i++) b0[119-8*i-:8] = f[i < 6 ? 6 + i : 10 + i];
         for (int i = 0; i < 9; i++) b1[111-8*i-:8] = f[12+i];
         t0 = aes(aes(b0, key) ^ b1, key) ^ aes({8'h01, b0[119:0]}, key);
         esig = t0[127:96];
         for (int i = 0; i < 4; i++) f.push_back(t0[127-8*i-:8]);
      end
      c = 24'h55_5555;
      for (int i = 4; i < f.size(); i++) for (int k = 0; k < 8; k++) begin
         fb = c[23] ^ f[i][k];
         c = {c[22:0], 1'b0} ^ (fb ? 24'h00_065B : 24'h00_0000);
      end
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 8; k++) rb[k] = c[23-8*i-k];
         f.push_back(rb);
      end
      foreach (f[i]) expq.push_back({i == f.size() - 1, f[i]});
      @(posedge clk); #1;
      snd = 0;
      eseq++;
      `CHK(seq, eseq)
   endtask : send
   // Monitor: each accepted byte is matched against the oldest note.
   always @(posedge clk) if (valid === 1'b1 && rdy === 1'b1 && en === 1'b1) begin
      if (expq.size() == 0) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time,
         data, 8'h00); end
      else begin
         `CHK(data, expq[0][7:0])
         `CHK(last, expq[0][8])
         void'(expq.pop_front());
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 0;
      send(1'b0, 3'h1);
      send(1'b1, 3'h0);
      for (int s = 0; s < 8; s++) send(1'b0, 3'(s));
      send(1'b1, 3'h5);
      for (int n = 0; n < 2000 && (expq.size() != 0 || busy !== 1'b0); n++) @(posedge clk);
      if (expq.size() != 0 || busy !== 1'b0) n_fail++;
      summarize();
   end
endmodule : tb_top
